// file: hdl/dual_timer_pkg.sv
// package: register map, field layout and reset values of the dual timer block
package dual_timer_pkg;
    // register byte offsets, per counter block of 0x20, then global interrupt registers from 0x100
    localparam logic [11:0] OFF_LOAD = 12'h000;
    localparam logic [11:0] OFF_VALUE = 12'h004;
    localparam logic [11:0] OFF_CTRL = 12'h008;
    localparam logic [11:0] OFF_INTCLR = 12'h00C;
    localparam logic [11:0] OFF_RIS = 12'h010;
    localparam logic [11:0] OFF_MIS = 12'h014;
    localparam logic [11:0] OFF_BGLOAD = 12'h018;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h100;
    localparam logic [11:0] OFF_IRQ_EN = 12'h104;
    localparam logic [11:0] OFF_IRQ_CLR = 12'h108;
    localparam int CTR_STRIDE_SHIFT = 5;
    localparam int UNIT_STRIDE_SHIFT = 6;
    // control field positions
    localparam int CTRL_ONESHOT = 0;
    localparam int CTRL_SIZE32 = 1;
    localparam int CTRL_PRE_LO = 2;
    localparam int CTRL_INTEN = 5;
    localparam int CTRL_PERIODIC = 6;
    localparam int CTRL_ENABLE = 7;
    localparam logic [7:0] CTRL_RESET = 8'h20;
    localparam logic [1:0] PRE_DIV1 = 2'h0;
    localparam logic [1:0] PRE_DIV16 = 2'h1;
    localparam logic [1:0] PRE_DIV256 = 2'h2;
    localparam logic [7:0] PRE_MAX16 = 8'h0F;
    localparam logic [7:0] PRE_MAX256 = 8'hFF;
    localparam logic [31:0] LOAD_RESET = 32'hFFFF_FFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: hdl/down_counter.sv
// one programmable down counter with prescaler and modes
`timescale 1ns/1ps
module down_counter
    import dual_timer_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] ctrl,
    input wire logic load_we,
    input wire logic bg_we,
    input wire logic [31:0] wdata,
    output logic [31:0] value,
    output logic [31:0] load_val,
    output logic zero_evt
);
    import dual_timer_pkg::*;

    logic [31:0] cnt_r;
    logic [31:0] load_r;
    logic [7:0] pre_r;
    logic halted_r;
    logic zero_r;

    wire en = ctrl[CTRL_ENABLE];
    wire size32 = ctrl[CTRL_SIZE32];
    wire [1:0] pre_sel = ctrl[CTRL_PRE_LO +: 2];
    wire [7:0] pre_max = (pre_sel == PRE_DIV16) ? PRE_MAX16 :
                         (pre_sel == PRE_DIV256) ? PRE_MAX256 : 8'h00;
    // prescaler divides the enabled clock by 1, 16 or 256
    wire tick = en && (pre_r >= pre_max);
    wire [31:0] masked = size32 ? cnt_r : {16'h0000, cnt_r[15:0]};
    wire at_zero = (masked == 32'h0000_0000);
    wire oneshot = ctrl[CTRL_ONESHOT];
    wire [31:0] wrap_val = ctrl[CTRL_PERIODIC] ? load_r :
                           (size32 ? 32'hFFFF_FFFF : 32'h0000_FFFF);
    wire stuck = oneshot && halted_r;
    wire [31:0] dec = masked - 32'h0000_0001;
    wire [31:0] cnt_nxt = load_we ? wdata :
                          (!tick || stuck) ? cnt_r :
                          at_zero ? wrap_val :
                          (size32 ? dec : {16'h0000, dec[15:0]});
    wire reach = tick && !stuck && !load_we && (masked == 32'h0000_0001);

    // prescale counter, restarts on load so a new count has a full first period
    always_ff @(posedge aclk) begin
        if (!aresetn || load_we || !en || tick)
            pre_r <= 8'h00;
        else
            pre_r <= pre_r + 8'h01;
    end

    // counter, load, one-shot halt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= LOAD_RESET;
            load_r <= LOAD_RESET;
            halted_r <= 1'b0;
            zero_r <= 1'b0;
        end else begin
            cnt_r <= oneshot && reach ? 32'h0000_0000 : cnt_nxt;
            if (load_we || bg_we)
                load_r <= wdata;
            if (load_we || !oneshot)
                halted_r <= 1'b0;
            else if (reach)
                halted_r <= 1'b1;
            zero_r <= reach;
        end
    end

    assign value = masked;
    assign load_val = load_r;
    assign zero_evt = zero_r;
endmodule

// file: hdl/dual_timer.sv
// top: two dual timer units, four down counters, AXI4-Lite register slave
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// ==================================================
module dual_timer
    import dual_timer_pkg::*;
#(
    parameter int UNITS = 2
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [UNITS-1:0] unit_irq,
    output logic irq
);
    import dual_timer_pkg::*;
    localparam int NCTR = 2 * UNITS;

    // ==================================================
    // write channel capture
    logic [11:0] awaddr_r;
    logic aw_have_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_have_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arvalid_seen;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready = !w_have_r && !bvalid_r;
    wire wr_go = aw_have_r && w_have_r && !bvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end else if (wr_go)
                aw_have_r <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (wr_go)
                w_have_r <= 1'b0;
        end
    end

    // ==================================================
    // address decoding
    function automatic logic is_ctr(input logic [11:0] a);
        return (a < 12'h100) && (a[CTR_STRIDE_SHIFT-1:0] < 5'h1C)
            && (a[1:0] == 2'b00) && (32'(a >> CTR_STRIDE_SHIFT) < NCTR);
    endfunction
    function automatic logic [4:0] ctr_off(input logic [11:0] a);
        return a[4:0];
    endfunction

    wire [1:0] wr_idx_w = awaddr_r[6:5];
    wire [4:0] wr_off = ctr_off(awaddr_r);
    wire wr_ctr = is_ctr(awaddr_r);
    wire wr_glob = (awaddr_r == OFF_IRQ_EN) || (awaddr_r == OFF_IRQ_CLR)
                   || (awaddr_r == OFF_IRQ_STAT);
    wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_ctr || wr_glob) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready)
            bvalid_r <= 1'b0;
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // ==================================================
    // per counter registers and counters
    logic [7:0] ctrl_r [NCTR];
    logic [NCTR-1:0] raw_r;
    logic [NCTR-1:0] en_r;
    logic [31:0] value_w [NCTR];
    logic [31:0] load_w [NCTR];
    logic [NCTR-1:0] zero_w;
    wire [NCTR-1:0] inten;
    wire [NCTR-1:0] masked;

    wire glob_clr_wr = wr_go && (awaddr_r == OFF_IRQ_CLR);
    wire glob_en_wr = wr_go && (awaddr_r == OFF_IRQ_EN);

    // prescale code 3 is undefined: treat as divide by 1
    function automatic logic [7:0] s_ctrl_fix(input logic [7:0] c);
        logic [7:0] r;
        r = c;
        if (c[CTRL_PRE_LO +: 2] == 2'h3)
            r[CTRL_PRE_LO +: 2] = PRE_DIV1;
        return r;
    endfunction

    genvar g;
    generate
        for (g = 0; g < NCTR; g++) begin : gen_ctr
            wire sel = wr_go && wr_ctr && (32'(wr_idx_w) == g);
            wire load_we = sel && (wr_off == OFF_LOAD[4:0]);
            wire bg_we = sel && (wr_off == OFF_BGLOAD[4:0]);
            wire clr_we = (sel && (wr_off == OFF_INTCLR[4:0]))
                          || (glob_clr_wr && wdata_r[g]);
            wire [31:0] wd = wdata_r & wmask;

            // control register, reset leaves counter stopped in free-running div1
            always_ff @(posedge aclk) begin
                if (!aresetn)
                    ctrl_r[g] <= CTRL_RESET;
                else if (sel && (wr_off == OFF_CTRL[4:0]) && wstrb_r[0])
                    ctrl_r[g] <= s_ctrl_fix(wdata_r[7:0]);
            end

            // sticky raw flag: a new zero beats a simultaneous clear
            always_ff @(posedge aclk) begin
                if (!aresetn)
                    raw_r[g] <= 1'b0;
                else if (zero_w[g])
                    raw_r[g] <= 1'b1;
                else if (clr_we)
                    raw_r[g] <= 1'b0;
            end

            assign inten[g] = ctrl_r[g][CTRL_INTEN] && en_r[g];
            assign masked[g] = raw_r[g] && inten[g];

            down_counter u_ctr (
                .aclk(aclk),
                .aresetn(aresetn),
                .ctrl(ctrl_r[g]),
                .load_we(load_we),
                .bg_we(bg_we),
                .wdata(wd),
                .value(value_w[g]),
                .load_val(load_w[g]),
                .zero_evt(zero_w[g])
            );
        end
        for (g = 0; g < UNITS; g++) begin : gen_unit
            assign unit_irq[g] = masked[2*g] || masked[2*g+1];
        end
    endgenerate

    // global enable register, same layout as the status register
    always_ff @(posedge aclk) begin
        if (!aresetn)
            en_r <= {NCTR{1'b1}};
        else if (glob_en_wr && wstrb_r[0])
            en_r <= wdata_r[NCTR-1:0];
    end
    assign irq = |masked;

    // ==================================================
    // read channel, one cycle to answer, same clock as counters
    wire [1:0] rd_idx = s_axi_araddr[6:5];
    wire [4:0] rd_off = ctr_off(s_axi_araddr);
    wire rd_ctr = is_ctr(s_axi_araddr);
    wire [7:0] rd_ctrl = ctrl_r[rd_idx];
    wire [31:0] rd_ctr_data =
        (rd_off == OFF_LOAD[4:0]) ? load_w[rd_idx] :
        (rd_off == OFF_BGLOAD[4:0]) ? load_w[rd_idx] :
        (rd_off == OFF_VALUE[4:0]) ? value_w[rd_idx] :
        (rd_off == OFF_CTRL[4:0]) ? {24'h000000, rd_ctrl} :
        (rd_off == OFF_RIS[4:0]) ? {31'h0, raw_r[rd_idx]} :
        (rd_off == OFF_MIS[4:0]) ? {31'h0, masked[rd_idx]} :
        32'h0000_0000;
    wire rd_stat = (s_axi_araddr == OFF_IRQ_STAT);
    wire rd_en = (s_axi_araddr == OFF_IRQ_EN);
    wire rd_clr = (s_axi_araddr == OFF_IRQ_CLR);
    logic [31:0] rd_mux;
    logic [1:0] rd_resp;

    // decode priority: counter block, then global registers, else error
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_resp = RESP_OKAY;
        if (rd_ctr)
            rd_mux = rd_ctr_data;
        else if (rd_stat)
            rd_mux = {{(32-NCTR){1'b0}}, raw_r};
        else if (rd_en)
            rd_mux = {{(32-NCTR){1'b0}}, en_r};
        else if (rd_clr)
            rd_mux = 32'h0000_0000; // write-only
        else
            rd_resp = RESP_SLVERR;
    end

    assign s_axi_arready = !rvalid_r;
    assign arvalid_seen = s_axi_arvalid && !rvalid_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (arvalid_seen) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_resp;
        end else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
endmodule

// file: bench/dual_timer_assertions.sv
// checker: port timing relations of the dual timer
`timescale 1ns/1ps
module dual_timer_assertions #(
    parameter int UNITS = 2
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [UNITS-1:0] unit_irq,
    input wire logic irq
);
    // ====
    // helper
    logic [2:0] since_w_r;
    // cycles since the last data beat; saturates so it never wraps
    always_ff @(posedge aclk) begin
        if (!aresetn || (s_axi_wvalid && s_axi_wready))
            since_w_r <= 3'h0;
        else if (since_w_r != 3'h7)
            since_w_r <= since_w_r + 3'h1;
    end
    // ====
    // properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (write_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered in time");
    a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answered twice");
    a_write_gate: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_read_answer: assert property (read_taken |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_read_gate: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_irq_or: assert property (irq == (|unit_irq))
        else $error("combined interrupt differs from units");
    a_irq_clear_cause: assert property ($fell(irq) |-> since_w_r <= 3'h4)
        else $error("interrupt dropped without a write");
    a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active after reset");
endmodule
bind dual_timer dual_timer_assertions #(.UNITS(UNITS)) chk (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .unit_irq, .irq);

// file: bench/axil_host.sv
// host model: AXI4-Lite master issuing one register access at a time
`timescale 1ns/1ps
module axil_host (
    input wire logic aclk,
    output logic [11:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [11:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    logic hung = 1'b0;
    // idle bus at time zero
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hF;
    end
    // address and data offered together; each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 60);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        hung = hung | (n >= 60);
    endtask
    // rready held from the request until data is sampled
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        n = 0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 60);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        hung = hung | (n >= 60);
    endtask
endmodule

// file: bench/tb.sv
// testbench: register-level tests of the dual timer
`timescale 1ns/1ps
module tb;
    import dual_timer_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr, s_axi_araddr, a;
    logic [31:0] s_axi_wdata, s_axi_rdata, v, m, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, unit_irq;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
    int miscompares = 0;
    int tests_run = 0;
    int dv;
    dual_timer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .unit_irq, .irq);
    axil_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // 100 ns clock
    initial begin
        forever #50 aclk = ~aclk;
    end
    // ====
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        if (host.hung)
            miscompares++;
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic w(input logic [11:0] ad, input logic [31:0] dt);
        host.wr(ad, dt, r);
        if (host.hung)
            wrap_up();
    endtask
    task automatic rchk(input logic [11:0] ad, input logic [31:0] exp);
        host.rd(ad, v, r);
        if (host.hung)
            wrap_up();
        check(v, exp);
    endtask
    // bounded wait; irq looked at away from the edge so it has settled
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(negedge aclk);
            n++;
        end
        check({31'h0, irq}, 32'h1);
        if (irq !== 1'b1)
            wrap_up();
    endtask
    // ====
    // sequence
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(OFF_CTRL, {24'h0, CTRL_RESET});
        rchk(OFF_VALUE, {16'h0000, LOAD_RESET[15:0]});
        rchk(OFF_RIS, 32'h0);
        check({30'h0, r}, {30'h0, RESP_OKAY});
        rchk(OFF_IRQ_EN, 32'hF);
        w(12'h0FC, 32'h0);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        rchk(12'h0FC, 32'h0);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        $display("test reset done");
        // one-shot: enable, inten, size32, oneshot
        w(OFF_LOAD, 32'h5);
        w(OFF_CTRL, 32'hA3);
        wait_irq;
        rchk(OFF_VALUE, 32'h0);
        rchk(OFF_MIS, 32'h1);
        check({30'h0, unit_irq}, 32'h1);
        w(OFF_CTRL, 32'h83);
        rchk(OFF_RIS, 32'h1);
        rchk(OFF_MIS, 32'h0);
        rchk(OFF_VALUE, 32'h0);
        w(OFF_INTCLR, 32'h0);
        rchk(OFF_RIS, 32'h0);
        $display("test one-shot done");
        // periodic; background value must not disturb the running count
        w(OFF_CTRL, 32'h0);
        w(OFF_LOAD, 32'h30);
        w(OFF_CTRL, 32'hE2);
        w(OFF_BGLOAD, 32'h40);
        host.rd(OFF_VALUE, v, r);
        check({31'h0, v <= 32'h30}, 32'h1);
        wait_irq;
        host.rd(OFF_VALUE, v, r);
        check({31'h0, v > 32'h30 && v <= 32'h40}, 32'h1);
        w(OFF_IRQ_EN, 32'h0);
        @(negedge aclk);
        check({31'h0, irq}, 32'h0);
        rchk(OFF_IRQ_STAT, 32'h1);
        w(OFF_CTRL, 32'h0);
        w(OFF_IRQ_CLR, 32'h1);
        rchk(OFF_IRQ_STAT, 32'h0);
        w(OFF_IRQ_EN, 32'hF);
        $display("test periodic done");
        // free-running wrap at 16 and 32 bits
        for (int i = 0; i < 2; i++) begin
            a = (i == 0) ? 12'h020 : 12'h040;
            m = (i == 0) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
            w(a + OFF_LOAD, 32'h3);
            w(a + OFF_CTRL, (i == 0) ? 32'h80 : 32'h82);
            repeat (8) @(posedge aclk);
            host.rd(a + OFF_VALUE, v, r);
            check({31'h0, v <= m && v > m - 32'h20}, 32'h1);
            rchk(a + OFF_RIS, 32'h1);
            w(a + OFF_CTRL, 32'h0);
        end
        $display("test wrap done");
        // prescale codes; load while running restarts the count
        for (int p = 0; p < 4; p++) begin
            dv = (p == 1) ? 16 : (p == 2) ? 256 : 1;
            w(12'h068, 32'h82 | (32'(p) << 2));
            if (p == 3)
                rchk(12'h068, 32'h82);
            w(12'h060, 32'h1000);
            repeat (512) @(posedge aclk);
            host.rd(12'h064, v, r);
            d = 32'h1000 - v;
            check({31'h0, d >= 32'(512 / dv) && d <= 32'(520 / dv + 1)}, 32'h1);
        end
        $display("test prescale done");
        wrap_up();
    end
endmodule
